// File: rtl/cspb_cfg.svh
/*
 Constants of the serial bit port: instruction codes, accumulator fields,
 register offsets, reset values and bit timing.
 Assumes inclusion by bare name from every design file that needs it.
*/
// Operation
// - Read-mask returns masks, pending flags, input level
// - Input line level appears in accumulator bit 7
// - Set-mask acts on accumulator bits it receives
// - Bit 3 or 4 set updates the masks
// - Bit 6 set updates the output line
// - Output line value comes from bit 7
// - Mask and output updates are independent
// - Bit 6 clear keeps output line level
// - One bit means high line level
// - Output line low after reset
// - Read-mask leaves the sign flag alone
// - Frame: start zero, eight data LSB first, stops
// - Two stop bits give eleven-bit frame
// - Line idles high between characters
// - Every bit lasts one bit period
// - Last data bit carries parity convention
// - Receiver samples each bit mid-period
// - Eight samples form byte, first is LSB
// - Receiver aligns to falling start edge
// - First sample at one and half bits
`ifndef CSPB_CFG_SVH
`define CSPB_CFG_SVH

`define CSPB_OP_READ_MASK 8'h20
`define CSPB_OP_SET_MASK 8'h30
`define CSPB_ACC_LINE_BIT 7
`define CSPB_ACC_OUT_EN 6
`define CSPB_ACC_MASK_EN_HI 4
`define CSPB_ACC_MASK_EN_LO 3

`define CSPB_REG_CTRL 5'h00
`define CSPB_REG_BITDIV 5'h04
`define CSPB_REG_TXDATA 5'h08
`define CSPB_REG_RXDATA 5'h0C
`define CSPB_REG_STATUS 5'h10

`define CSPB_CTRL_TWO_STOP 0
`define CSPB_CTRL_RX_EN 1
`define CSPB_CTRL_RESET 2'h2

`define CSPB_FRAME_SHORT 4'hA
`define CSPB_FRAME_LONG 4'hB

`define CSPB_CLK_HZ 200000000
`define CSPB_DEF_BAUD 9600
`define CSPB_BIT_CYCLES (`CSPB_CLK_HZ / `CSPB_DEF_BAUD)

`endif

// File: rtl/cspb_pkg.sv
/*
 Types and shared arithmetic of the serial bit port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cspb_pkg;

    typedef enum logic [3:0] {
        CSPB_RX_IDLE = 4'h1,
        CSPB_RX_START = 4'h2,
        CSPB_RX_DATA = 4'h4,
        CSPB_RX_STOP = 4'h8
    } cspb_rx_state_t;

    typedef enum logic [1:0] {
        CSPB_TX_IDLE = 2'h1,
        CSPB_TX_BIT = 2'h2
    } cspb_tx_state_t;

    // Reload value of a down counter, never below zero
    function automatic logic [15:0] cspb_load(input logic [15:0] n);
        return (n == 16'h0000) ? 16'h0000 : n - 16'h0001;
    endfunction

endpackage
`default_nettype wire

// File: rtl/cspb_rx_if.sv
/*
 Link between the port's control logic and its character receiver.
 Assumes both ends run on the same clock.
*/
`default_nettype none
interface cspb_rx_if;
    logic lineIn;
    logic enable;
    logic [15:0] bitCycles;
    logic [7:0] rxByte;
    logic rxStb;
    logic frameErr;
    logic busy;

    modport ctl(output lineIn, enable, bitCycles, input rxByte, rxStb, frameErr, busy);
    modport rx(input lineIn, enable, bitCycles, output rxByte, rxStb, frameErr, busy);
endinterface
`default_nettype wire

// File: rtl/cspb_rx.sv
/*
 Character receiver: waits for a falling start edge, samples mid-bit,
 assembles eight data bits LSB first and checks the first stop bit.
 Assumes lineIn is already synchronised to sys_clk.
*/
`default_nettype none
`include "cspb_cfg.svh"
module cspb_rx (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    cspb_rx_if.rx port
);
    cspb_pkg::cspb_rx_state_t stateQ, stateD;
    logic [15:0] cntQ, cntD;
    logic [2:0] bitQ, bitD;
    logic [7:0] shQ, shD, byteQ, byteD;
    logic prevQ, prevD, stbQ, stbD, errQ, errD;

    always_comb begin
        stateD = stateQ;
        cntD = cntQ;
        bitD = bitQ;
        shD = shQ;
        byteD = byteQ;
        stbD = 1'h0;
        errD = errQ;
        prevD = port.lineIn;
        case (stateQ)
            cspb_pkg::CSPB_RX_IDLE: begin
                if (port.enable && prevQ && !port.lineIn) begin
                    stateD = cspb_pkg::CSPB_RX_START;
                    cntD = cspb_pkg::cspb_load({1'h0, port.bitCycles[15:1]});
                end
            end
            cspb_pkg::CSPB_RX_START: begin
                if (cntQ != 16'h0000) begin
                    cntD = cntQ - 16'h0001;
                end else if (!port.lineIn) begin
                    // Mid start bit; one more period puts us mid data bit 0
                    stateD = cspb_pkg::CSPB_RX_DATA;
                    cntD = cspb_pkg::cspb_load(port.bitCycles);
                    bitD = 3'h0;
                end else begin
                    stateD = cspb_pkg::CSPB_RX_IDLE;
                end
            end
            cspb_pkg::CSPB_RX_DATA: begin
                if (cntQ != 16'h0000) begin
                    cntD = cntQ - 16'h0001;
                end else begin
                    shD = {port.lineIn, shQ[7:1]};
                    cntD = cspb_pkg::cspb_load(port.bitCycles);
                    bitD = bitQ + 3'h1;
                    if (bitQ == 3'h7) begin
                        stateD = cspb_pkg::CSPB_RX_STOP;
                    end
                end
            end
            cspb_pkg::CSPB_RX_STOP: begin
                if (cntQ != 16'h0000) begin
                    cntD = cntQ - 16'h0001;
                end else begin
                    byteD = shQ;
                    stbD = 1'h1;
                    errD = !port.lineIn;
                    stateD = cspb_pkg::CSPB_RX_IDLE;
                end
            end
            default: stateD = cspb_pkg::CSPB_RX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateQ <= cspb_pkg::CSPB_RX_IDLE;
            cntQ <= 16'h0000;
            bitQ <= 3'h0;
            shQ <= 8'h00;
            byteQ <= 8'h00;
            prevQ <= 1'h1;
            stbQ <= 1'h0;
            errQ <= 1'h0;
        end else if (ce) begin
            stateQ <= stateD;
            cntQ <= cntD;
            bitQ <= bitD;
            shQ <= shD;
            byteQ <= byteD;
            prevQ <= prevD;
            stbQ <= stbD;
            errQ <= errD;
        end
    end

    assign port.rxByte = byteQ;
    assign port.rxStb = stbQ;
    assign port.frameErr = errQ;
    assign port.busy = (stateQ != cspb_pkg::CSPB_RX_IDLE);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_start_edge;
        ce && stateQ == cspb_pkg::CSPB_RX_IDLE && port.enable && prevQ && !port.lineIn;
    endsequence
    sequence s_mid_start;
        ce && stateQ == cspb_pkg::CSPB_RX_START && cntQ == 16'h0000 && !port.lineIn;
    endsequence

    a_rx_edge_arm: assert property (s_start_edge |=> stateQ == cspb_pkg::CSPB_RX_START)
        else $error("start edge did not arm receiver");
    a_rx_first_sample: assert property (s_mid_start |=>
        stateQ == cspb_pkg::CSPB_RX_DATA && cntQ == cspb_pkg::cspb_load($past(port.bitCycles)))
        else $error("first data sample not one period after mid start");
    a_rx_lsb_first: assert property (ce && stateQ == cspb_pkg::CSPB_RX_DATA && cntQ == 16'h0000
        |=> shQ[7] == $past(port.lineIn) && shQ[6:0] == $past(shQ[7:1]))
        else $error("sample not shifted in from the top");
    a_rx_byte_out: assert property (ce && stateQ == cspb_pkg::CSPB_RX_STOP && cntQ == 16'h0000
        |=> stbQ && byteQ == $past(shQ) && stateQ == cspb_pkg::CSPB_RX_IDLE)
        else $error("received byte not delivered at stop sample");
endmodule
`default_nettype wire

// File: rtl/cspb_serial_bit_port.sv
/*
 Serial bit port of an 8-bit processor: executes the read-mask and
 set-mask accumulator instructions, holds the interrupt masks and the
 serial output level, and offers a framed character transmitter and
 receiver through a small register port.
 Assumes the instruction port and register port are driven from sys_clk
 logic; serial input and pending flags come from pins and are synchronised.
*/
`default_nettype none
`include "cspb_cfg.svh"
module cspb_serial_bit_port #(
    parameter logic [15:0] BIT_CYCLES = 16'(`CSPB_BIT_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic instrStb,
    input wire logic [7:0] instrOpcode,
    input wire logic [7:0] instrAcc,
    input wire logic intEnable,
    input wire logic [2:0] intPendingPin,
    input wire logic serialInLine,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    output logic [7:0] accOut,
    output logic accOutStb,
    output logic [2:0] intMask,
    output logic serialOutLine
);
    // Pin synchronisers
    logic sidMetaQ, sidQ;
    logic [2:0] pendMetaQ, pendQ;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sidMetaQ <= 1'h1;
            sidQ <= 1'h1;
            pendMetaQ <= 3'h0;
            pendQ <= 3'h0;
        end else if (ce) begin
            sidMetaQ <= serialInLine;
            sidQ <= sidMetaQ;
            pendMetaQ <= intPendingPin;
            pendQ <= pendMetaQ;
        end
    end

    // Instruction decode
    logic rimOp, simOp, simMask, simOut;

    assign rimOp = instrStb && (instrOpcode == `CSPB_OP_READ_MASK);
    assign simOp = instrStb && (instrOpcode == `CSPB_OP_SET_MASK);
    assign simMask = simOp && (instrAcc[`CSPB_ACC_MASK_EN_LO] || instrAcc[`CSPB_ACC_MASK_EN_HI]);
    assign simOut = simOp && instrAcc[`CSPB_ACC_OUT_EN];

    // Register file state
    logic twoStopQ, twoStopD, rxEnQ, rxEnD;
    logic [15:0] bitCycQ, bitCycD, rdDataQ, rdDataD;
    logic [7:0] rxDataQ, rxDataD;
    logic rxValidQ, rxValidD, frameErrQ, frameErrD;

    // Transmit sequencer state
    cspb_pkg::cspb_tx_state_t txStateQ, txStateD;
    logic [15:0] txCntQ, txCntD;
    logic [10:0] txShQ, txShD;
    logic [3:0] txLeftQ, txLeftD;
    logic engSet, engBit, txGo;

    // Instruction state
    logic [2:0] maskQ, maskD;
    logic sodQ, sodD;
    logic [7:0] accQ, accD;
    logic accStbQ, accStbD;

    cspb_rx_if rxBus();

    assign rxBus.lineIn = sidQ;
    assign rxBus.enable = rxEnQ;
    assign rxBus.bitCycles = bitCycQ;

    cspb_rx u_rx (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .port(rxBus)
    );

    assign txGo = regWrStb && (regAddr == `CSPB_REG_TXDATA) && (txStateQ == cspb_pkg::CSPB_TX_IDLE);

    always_comb begin
        txStateD = txStateQ;
        txCntD = txCntQ;
        txShD = txShQ;
        txLeftD = txLeftQ;
        engSet = 1'h0;
        engBit = 1'h1;
        case (txStateQ)
            cspb_pkg::CSPB_TX_IDLE: begin
                if (txGo) begin
                    // Stop bits above the data, start bit at the bottom
                    txShD = {2'h3, regWrData[7:0], 1'h0};
                    txLeftD = twoStopQ ? `CSPB_FRAME_LONG : `CSPB_FRAME_SHORT;
                    txCntD = cspb_pkg::cspb_load(bitCycQ);
                    txStateD = cspb_pkg::CSPB_TX_BIT;
                    engSet = 1'h1;
                    engBit = 1'h0;
                end
            end
            cspb_pkg::CSPB_TX_BIT: begin
                if (txCntQ != 16'h0000) begin
                    txCntD = txCntQ - 16'h0001;
                end else if (txLeftQ == 4'h1) begin
                    txStateD = cspb_pkg::CSPB_TX_IDLE;
                end else begin
                    txShD = {1'h1, txShQ[10:1]};
                    txLeftD = txLeftQ - 4'h1;
                    txCntD = cspb_pkg::cspb_load(bitCycQ);
                    engSet = 1'h1;
                    engBit = txShQ[1];
                end
            end
            default: txStateD = cspb_pkg::CSPB_TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            txStateQ <= cspb_pkg::CSPB_TX_IDLE;
            txCntQ <= 16'h0000;
            txShQ <= 11'h7FF;
            txLeftQ <= 4'h0;
        end else if (ce) begin
            txStateQ <= txStateD;
            txCntQ <= txCntD;
            txShQ <= txShD;
            txLeftQ <= txLeftD;
        end
    end

    always_comb begin
        maskD = maskQ;
        sodD = sodQ;
        accD = accQ;
        accStbD = 1'h0;
        if (simMask) begin
            maskD = instrAcc[2:0];
        end
        // A processor write wins over the transmitter in the same cycle
        if (simOut) begin
            sodD = instrAcc[`CSPB_ACC_LINE_BIT];
        end else if (engSet) begin
            sodD = engBit;
        end
        if (rimOp) begin
            // Only the accumulator is loaded; no flag is touched
            accD = {sidQ, pendQ, intEnable, maskQ};
            accStbD = 1'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            maskQ <= 3'h7;
            sodQ <= 1'h0;
            accQ <= 8'h00;
            accStbQ <= 1'h0;
        end else if (ce) begin
            maskQ <= maskD;
            sodQ <= sodD;
            accQ <= accD;
            accStbQ <= accStbD;
        end
    end

    always_comb begin
        twoStopD = twoStopQ;
        rxEnD = rxEnQ;
        bitCycD = bitCycQ;
        rxDataD = rxDataQ;
        rxValidD = rxValidQ;
        frameErrD = frameErrQ;
        rdDataD = 16'h0000;
        if (regWrStb) begin
            if (regAddr == `CSPB_REG_CTRL) begin
                twoStopD = regWrData[`CSPB_CTRL_TWO_STOP];
                rxEnD = regWrData[`CSPB_CTRL_RX_EN];
            end else if (regAddr == `CSPB_REG_BITDIV) begin
                bitCycD = regWrData;
            end
        end
        if (regRdStb) begin
            if (regAddr == `CSPB_REG_CTRL) begin
                rdDataD = {14'h0000, rxEnQ, twoStopQ};
            end else if (regAddr == `CSPB_REG_BITDIV) begin
                rdDataD = bitCycQ;
            end else if (regAddr == `CSPB_REG_RXDATA) begin
                rdDataD = {7'h00, rxValidQ, rxDataQ};
                rxValidD = 1'h0;
            end else if (regAddr == `CSPB_REG_STATUS) begin
                rdDataD = {10'h000, sidQ, sodQ, frameErrQ, rxValidQ, rxBus.busy,
                    (txStateQ != cspb_pkg::CSPB_TX_IDLE)};
            end
        end
        // A new byte beats a read that clears the valid flag
        if (rxBus.rxStb) begin
            rxDataD = rxBus.rxByte;
            rxValidD = 1'h1;
            frameErrD = rxBus.frameErr;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            twoStopQ <= 1'(`CSPB_CTRL_RESET >> `CSPB_CTRL_TWO_STOP);
            rxEnQ <= 1'(`CSPB_CTRL_RESET >> `CSPB_CTRL_RX_EN);
            bitCycQ <= BIT_CYCLES;
            rxDataQ <= 8'h00;
            rxValidQ <= 1'h0;
            frameErrQ <= 1'h0;
            rdDataQ <= 16'h0000;
        end else if (ce) begin
            twoStopQ <= twoStopD;
            rxEnQ <= rxEnD;
            bitCycQ <= bitCycD;
            rxDataQ <= rxDataD;
            rxValidQ <= rxValidD;
            frameErrQ <= frameErrD;
            rdDataQ <= rdDataD;
        end
    end

    assign regRdData = rdDataQ;
    assign accOut = accQ;
    assign accOutStb = accStbQ;
    assign intMask = maskQ;
    assign serialOutLine = sodQ;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_tx_go;
        ce && txGo && !simOut;
    endsequence
    sequence s_last_stop;
        ce && txStateQ == cspb_pkg::CSPB_TX_BIT && txCntQ == 16'h0000 && txLeftQ == 4'h2 && !simOut;
    endsequence

    a_sod_update: assert property (ce && simOut |=> sodQ == $past(instrAcc[7]))
        else $error("output line not taken from accumulator bit 7");
    a_sod_hold: assert property (ce && simOp && !instrAcc[6] && !engSet |=> $stable(sodQ))
        else $error("output line moved without bit 6");
    a_mask_update: assert property (ce && simMask |=> intMask == $past(instrAcc[2:0]))
        else $error("masks not updated by set-mask");
    a_mask_hold: assert property (ce && simOp && !instrAcc[3] && !instrAcc[4] |=> $stable(intMask))
        else $error("masks changed with bits 3 and 4 clear");
    a_rim_line: assert property (ce && rimOp |=>
        accOutStb && accOut[7] == $past(sidQ) && accOut[2:0] == $past(maskQ))
        else $error("read-mask result wrong");
    a_rd_window: assert property (ce && !regRdStb |=> regRdData == 16'h0000)
        else $error("read data outside its cycle");
    a_tx_start_low: assert property (s_tx_go |=> !sodQ && txStateQ == cspb_pkg::CSPB_TX_BIT)
        else $error("frame did not open with a low start bit");
    a_tx_frame_len: assert property (s_tx_go |=>
        txLeftQ == ($past(twoStopQ) ? `CSPB_FRAME_LONG : `CSPB_FRAME_SHORT))
        else $error("frame length wrong");
    a_tx_stop_high: assert property (s_last_stop |=> sodQ)
        else $error("last stop bit not high");
endmodule
`default_nettype wire

// File: testbench/cspb_term_model.sv
/*
 Serial terminal on the far side of the port: sends framed characters
 onto the port's input pin and decodes frames seen on its output pin.
 Assumes callers start its tasks just after a rising edge of sys_clk.
*/
`default_nettype none
module cspb_term_model #(
    parameter int N = 8
) (
    input wire logic sys_clk,
    input wire logic lineFromDut,
    input wire logic listen,
    input wire logic twoStop,
    output var logic lineToDut,
    output var logic [7:0] rxByte,
    output var logic stopOk,
    output var logic rxStb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lastQ = 1'b0;
    initial begin
        lineToDut = 1'b1;
        rxByte = 8'h00;
        stopOk = 1'b0;
        rxStb = 1'b0;
    end
    task automatic hold(input logic v);
        lineToDut <= v;
    endtask
    task automatic send(input logic [7:0] b, input logic stopVal);
        logic [9:0] f;
        f = {stopVal, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            lineToDut <= f[i];
            repeat (N) @(posedge sys_clk);
        end
        lineToDut <= 1'b1;
    endtask
    // The reset-low line never counts as a start: only a high-to-low step does
    always begin : decode
        logic [7:0] b;
        logic ok;
        @(posedge sys_clk);
        rxStb <= 1'b0;
        if (listen && lastQ === 1'b1 && lineFromDut === 1'b0) begin
            repeat (N / 2) @(posedge sys_clk);
            ok = ~lineFromDut;
            for (int i = 0; i < 8; i++) begin
                repeat (N) @(posedge sys_clk);
                b[i] = lineFromDut;
            end
            repeat (N) @(posedge sys_clk);
            ok = ok & lineFromDut;
            if (twoStop) begin
                repeat (N) @(posedge sys_clk);
                ok = ok & lineFromDut;
            end
            rxByte <= b;
            stopOk <= ok;
            rxStb <= 1'b1;
        end
        lastQ = lineFromDut;
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/*
 Self-checking bench of the serial bit port with a terminal model.
 Assumes the design files and the terminal model are compiled first.
*/
`default_nettype none
`include "cspb_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] NB = 16'h0008;
    localparam int N = 8;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic instrStb = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0, intEnable = 1'b0;
    logic [7:0] instrOpcode = 8'h00, instrAcc = 8'h00, accOut, tByte;
    logic [2:0] intPendingPin = 3'h0, intMask;
    logic [4:0] regAddr = 5'h00;
    logic [15:0] regWrData = 16'h0000, regRdData;
    logic accOutStb, serialOutLine, serialInLine, tStop, tStb;
    logic listenTb = 1'b0, twoStopTb = 1'b0, rdFlag = 1'b0, ce = 1'b1;
    logic [7:0] expAcc[$];
    logic [15:0] expRd[$];
    logic [8:0] expTerm[$];
    int n_errors = 0;
    int check_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    cspb_serial_bit_port #(.BIT_CYCLES(NB)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
        .instrStb(instrStb), .instrOpcode(instrOpcode), .instrAcc(instrAcc), .intEnable(intEnable),
        .intPendingPin(intPendingPin), .serialInLine(serialInLine), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .accOut(accOut), .accOutStb(accOutStb), .intMask(intMask), .serialOutLine(serialOutLine));
    cspb_term_model #(.N(N)) term (.sys_clk(sys_clk), .lineFromDut(serialOutLine), .listen(listenTb),
        .twoStop(twoStopTb), .lineToDut(serialInLine), .rxByte(tByte), .stopOk(tStop), .rxStb(tStb));
    task automatic finish_test();
        n_errors += expAcc.size() + expRd.size() + expTerm.size();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_rd(input logic [15:0] e);
        chk("regRdData", e, regRdData);
    endtask
    task automatic chk_acc(input logic [7:0] e);
        chk("accOut", {8'h00, e}, {8'h00, accOut});
    endtask
    task automatic chk_term(input logic [8:0] e);
        chk("terminal byte", {7'h00, e}, {7'h00, tStop, tByte});
    endtask
    task automatic chk_mask(input logic [2:0] e);
        chk("intMask", {13'h0000, e}, {13'h0000, intMask});
    endtask
    task automatic chk_line(input logic e);
        chk("serialOutLine", {15'h0000, e}, {15'h0000, serialOutLine});
    endtask
    // Results are taken once the edge's own updates have landed
    always begin
        @(posedge sys_clk);
        #1;
        if (rdFlag)
            chk_rd(expRd.size() ? expRd.pop_front() : 16'hXXXX);
        rdFlag = regRdStb;
        if (accOutStb === 1'b1)
            chk_acc(expAcc.size() ? expAcc.pop_front() : 8'hXX);
        if (tStb === 1'b1)
            chk_term(expTerm.size() ? expTerm.pop_front() : 9'h1XX);
    end
    task automatic instr(input logic [7:0] op, input logic [7:0] acc);
        @(posedge sys_clk);
        instrStb <= 1'b1;
        instrOpcode <= op;
        instrAcc <= acc;
        @(posedge sys_clk);
        instrStb <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        expRd.push_back(e);
        @(posedge sys_clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
    endtask
    initial begin
        repeat (50000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end
    initial begin : main
        logic [7:0] acc, op, b;
        logic [2:0] mask;
        logic line;
        void'($urandom(32'h3D6C3A64));
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        chk_mask(3'h7);
        chk_line(1'b0);
        rd(`CSPB_REG_CTRL, 16'h0002);
        rd(`CSPB_REG_BITDIV, NB);
        rd(`CSPB_REG_STATUS, 16'h0020);
        wr(5'h14, 16'h0000);
        rd(5'h1C, 16'h0000);
        rd(`CSPB_REG_CTRL, 16'h0002);
        wr(`CSPB_REG_BITDIV, 16'h00A5);
        rd(`CSPB_REG_BITDIV, 16'h00A5);
        wr(`CSPB_REG_BITDIV, NB);
        // With the clock enable low a set-mask must leave no trace
        ce <= 1'b0;
        instr(`CSPB_OP_SET_MASK, 8'hDA);
        @(posedge sys_clk);
        ce <= 1'b1;
        #1;
        chk_mask(3'h7);
        chk_line(1'b0);
        $display("test reset done");
        mask = 3'h7;
        line = 1'b0;
        for (int i = 0; i < 24; i++) begin
            acc = 8'($urandom);
            // Odd codes can never be one of the two instructions
            op = (i % 5 == 4) ? (8'($urandom) | 8'h01) : `CSPB_OP_SET_MASK;
            instr(op, acc);
            if (op == `CSPB_OP_SET_MASK && (acc[3] || acc[4]))
                mask = acc[2:0];
            if (op == `CSPB_OP_SET_MASK && acc[6])
                line = acc[7];
            @(posedge sys_clk);
            #1;
            chk_mask(mask);
            chk_line(line);
        end
        $display("test set-mask done");
        // Receiver off so that level changes on the input pin start no frame
        wr(`CSPB_REG_CTRL, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            @(posedge sys_clk);
            term.hold(b[0]);
            intPendingPin <= b[3:1];
            intEnable <= b[4];
            repeat (4) @(posedge sys_clk);
            expAcc.push_back({b[0], b[3:1], b[4], mask});
            instr(`CSPB_OP_READ_MASK, 8'($urandom));
            @(posedge sys_clk);
            #1;
            chk_mask(mask);
        end
        @(posedge sys_clk);
        term.hold(1'b1);
        $display("test read-mask done");
        instr(`CSPB_OP_SET_MASK, 8'hC0);
        repeat (100) @(posedge sys_clk);
        listenTb <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            twoStopTb <= s[0];
            wr(`CSPB_REG_CTRL, {15'h0000, s[0]});
            for (int k = 0; k < 3; k++) begin
                b = 8'($urandom);
                expTerm.push_back({1'b1, b});
                wr(`CSPB_REG_TXDATA, {8'h00, b});
                wr(`CSPB_REG_TXDATA, {8'h00, ~b});
                // Next write lands two cycles after the frame ends, for short and long frames alike
                if (s == 1) begin
                    repeat (10 * N - 1) @(posedge sys_clk);
                    rd(`CSPB_REG_STATUS, 16'h0031);
                    repeat (N - 3) @(posedge sys_clk);
                end else begin
                    repeat (10 * N - 2) @(posedge sys_clk);
                end
            end
            repeat (N) @(posedge sys_clk);
        end
        repeat (12 * N) @(posedge sys_clk);
        $display("test transmit done");
        wr(`CSPB_REG_CTRL, 16'h0002);
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            if (k == 2)
                b[7] = 1'b0;
            term.send(b, k != 2);
            repeat (N) @(posedge sys_clk);
            rd(`CSPB_REG_RXDATA, {7'h00, 1'b1, b});
            rd(`CSPB_REG_RXDATA, {7'h00, 1'b0, b});
            rd(`CSPB_REG_STATUS, k == 2 ? 16'h0038 : 16'h0030);
        end
        $display("test receive done");
        repeat (20) @(posedge sys_clk);
        finish_test();
    end
endmodule
`default_nettype wire
